// *** dv/hftx_dp_model.sv ***
// Display processor model: issues control words as an AHB-Lite master.
// Assumes hready is the one slave's hreadyout; calls start just after a rising edge.
`timescale 1ns/1ps
module hftx_dp_model import hftx_pkg::*; (
  // Clock and bus answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Set when a wait ran out
  output logic hung
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = HFTX_HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // Bounded wait so a stuck slave cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 64) hung = 1'b1;
  endtask : wait_ready

  // One single word transfer; address phase held until hready
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    hsel <= 1'b1;
    htrans <= HFTX_HTRANS_NONSEQ;
    haddr <= addr;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    htrans <= HFTX_HTRANS_IDLE;
    hsel <= 1'b0;
    hwdata <= wr ? wdata : ~hwdata;
    wait_ready();
    rdata = hrdata;
    // Released data lines show the inverse, never a stale copy
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : hftx_dp_model

// *** dv/testbench.sv ***
// Self-checking bench for the transmit path control block.
// Assumes the display processor model drives the bus; hready is hreadyout.
`timescale 1ns/1ps
`include "hftx_map.svh"
module testbench import hftx_pkg::*;;
  logic hclk;
  logic hresetn;
  wire hsel;
  wire [11:0] haddr;
  wire [1:0] htrans;
  wire hwrite;
  wire [2:0] hsize;
  wire [31:0] hwdata;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire dp_hung;
  wire [7:0] drive_filter_en;
  wire [3:0] harm_relay;
  wire pa_connect, speech_proc_en, voice_gain_leveller_en, message_unit_modem_source;
  wire phasing_en, carrier_imbalance_drive, carrier_0, carrier_90, sidetone_tone;
  wire modulator_a1, modulator_a2, modulator_b1, modulator_b2;
  wire [1:0] sidetone_src, bias_sel, power_ref;
  wire [6:0] mvec;
  int num_errors = 0;
  int check_count = 0;

  // Mode-dependent outputs gathered for same-cycle comparison
  assign mvec = {speech_proc_en, voice_gain_leveller_en, message_unit_modem_source,
                 phasing_en, carrier_imbalance_drive, sidetone_src};

  hftx_dp_model u_dp (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hung(dp_hung));

  hftx_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .drive_filter_en(drive_filter_en), .harm_relay(harm_relay), .pa_connect(pa_connect),
    .speech_proc_en(speech_proc_en), .voice_gain_leveller_en(voice_gain_leveller_en),
    .message_unit_modem_source(message_unit_modem_source), .phasing_en(phasing_en),
    .carrier_imbalance_drive(carrier_imbalance_drive), .sidetone_src(sidetone_src),
    .carrier_0(carrier_0), .carrier_90(carrier_90), .modulator_a1(modulator_a1),
    .modulator_a2(modulator_a2), .modulator_b1(modulator_b1), .modulator_b2(modulator_b2),
    .sidetone_tone(sidetone_tone), .bias_sel(bias_sel), .power_ref(power_ref));

  // 250 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Bus access; a stuck bus ends the run
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    u_dp.xfer(wr, a, d, r);
    check(hresp, 1'b0, "bus response");
    if (dp_hung !== 1'b0) begin
      num_errors++;
      $display("mismatch at %0t: bus wait timed out", $time);
      end_of_test();
    end
  endtask : acc

  // Write, then wait two edges; decoded outputs land one edge after the register
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
    repeat (2) @(posedge hclk);
    #1;
  endtask : wr

  function automatic logic [6:0] mode_vec(input int m);
    logic [1:0] s;
    s = (m == 1) ? 2'h0 : ((m == 0) ? 2'h2 : 2'h1);
    return {m == 1, m == 1, m >= 2 && m <= 4, m != 0, m == 0, s};
  endfunction : mode_vec

  task automatic test_reset();
    check(drive_filter_en, 8'h01, "reset drive");
    check(mvec, mode_vec(0), "reset mode outputs");
    check({harm_relay, pa_connect, bias_sel}, 7'h00, "reset relays");
    $display("test reset done");
  endtask : test_reset

  task automatic test_filters();
    logic [31:0] r;
    for (int d = 0; d < 8; d++) begin
      wr(`HFTX_OFF_FILT, d);
      check(drive_filter_en, 8'h01 << d, "drive decode");
    end
    wr(`HFTX_OFF_CTRL, 32'h0000_0100);
    for (int h = 0; h < 4; h++) begin
      wr(`HFTX_OFF_FILT, h << 4);
      check(harm_relay, 4'h1 << h, "harmonic decode");
    end
    wr(`HFTX_OFF_CTRL, 32'h0000_0000);
    check(harm_relay, 4'h0, "harmonic in receive");
    acc(1'b0, `HFTX_OFF_FILT, 32'h0, r);
    check(r, 32'h0000_0030, "filter readback");
    acc(1'b0, 12'h0f0, 32'h0, r);
    check(r, 32'h0000_0000, "unmapped read");
    $display("test filters done");
  endtask : test_filters

  task automatic test_modes();
    logic [6:0] prev;
    logic [31:0] r;
    int m;
    prev = mode_vec(0);
    for (int i = 1; i <= 6; i++) begin
      m = i % 6;
      acc(1'b1, `HFTX_OFF_CTRL, m, r);
      // Every cycle shows either the old set or the new set, never a blend
      for (int c = 0; c < 4; c++) begin
        @(posedge hclk);
        #1;
        check(mvec === prev || mvec === mode_vec(m), 1'b1, "mode outputs split");
      end
      check(mvec, mode_vec(m), "mode routing");
      if (m == 0) check({modulator_a1, modulator_a2}, 2'h0, "cw phasing off");
      else check({modulator_b1, modulator_b2}, {!modulator_a1, !modulator_a2}, "antiphase");
      if (m != 0) check(sidetone_tone, 1'b0, "sidetone idle");
      prev = mode_vec(m);
    end
    $display("test modes done");
  endtask : test_modes

  task automatic test_power();
    logic [31:0] r;
    for (int p = 0; p < 6; p++) begin
      wr(`HFTX_OFF_CTRL, 32'h0000_0301 | (p << 4));
      check(power_ref, (p == 2) ? 2'h1 : ((p == 3) ? 2'h2 : 2'h0), "power ref");
      check(bias_sel, (p == 4) ? 2'h3 : 2'h0, "bias select");
      check(pa_connect, p != 0, "pa relay");
    end
    wr(`HFTX_OFF_CTRL, 32'h0000_0231);
    check({pa_connect, bias_sel}, 3'h0, "receive isolates pa");
    // Voice, high power, receive: speech and phasing on, reference high
    acc(1'b0, `HFTX_OFF_STAT, 32'h0, r);
    check(r, 32'h0000_0025, "status readback");
    acc(1'b0, `HFTX_OFF_DRV, 32'h0, r);
    check(r, 32'h0000_0001, "drive readback");
    $display("test power done");
  endtask : test_power

  // Carrier period and quarter-cycle lag, measured from two rises of carrier_0
  task automatic test_carrier();
    int n, first, lag;
    logic p0, p90;
    first = -1;
    lag = -1;
    p0 = carrier_0;
    p90 = carrier_90;
    for (n = 0; n < 1800; n++) begin
      @(posedge hclk);
      #1;
      if (carrier_0 === 1'b1 && p0 === 1'b0) begin
        if (first >= 0) break;
        first = n;
      end
      if (carrier_90 === 1'b1 && p90 === 1'b0 && first >= 0 && lag < 0) lag = n - first;
      p0 = carrier_0;
      p90 = carrier_90;
    end
    // Four reference periods per carrier period; quarter lag is one reference period
    check(n - first, 8 * `HFTX_QREF_HALF, "carrier period");
    check(lag, 2 * `HFTX_QREF_HALF, "carrier lag");
    $display("test carrier done");
  endtask : test_carrier

  // Message-mode tone: a2 changes a quarter period after a1
  task automatic test_tone();
    int n, first, d;
    logic pa1, pa2;
    wr(`HFTX_OFF_CTRL, 32'h0000_0005);
    first = -1;
    d = -1;
    pa1 = modulator_a1;
    pa2 = modulator_a2;
    for (n = 0; n < 90000 && d < 0; n++) begin
      @(posedge hclk);
      #1;
      if (modulator_a1 !== pa1 && first < 0) first = n;
      else if (modulator_a2 !== pa2 && first >= 0) d = n - first;
      pa1 = modulator_a1;
      pa2 = modulator_a2;
    end
    check(d >= `HFTX_MSG_QTR - 2 && d <= `HFTX_MSG_QTR + 2, 1'b1, "tone quadrature");
    check(modulator_b1, !modulator_a1, "tone antiphase");
    $display("test tone done");
  endtask : test_tone

  // Main sequence
  initial begin
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    test_reset();
    test_filters();
    test_modes();
    test_power();
    test_carrier();
    test_tone();
    end_of_test();
  end
endmodule : testbench

// *** rtl/hftx_ctrl.sv ***
// Transmit path control: filter decode, mode routing, tone dividers, bias.
// Assumes a single AHB-Lite master; all divided references run on hclk.
// Contract
// - Three-bit code drives one of eight lines
// - Only selected drive filter input enabled
// - Two-bit code energises one harmonic relay
// - Receiving de-energises all harmonic relays
// - Reference divided by four, quadrature carriers
// - Speech processing only in voice mode
// - Voice: quadrature tones to first pair
// - Second pair tones antiphase to first
// - Message 2.2 kHz, data 2 kHz tone
// - CW disables phasing, asserts imbalance drive
// - Message mode routes phaser to modulators
// - Data mode routes modem tone via bandpass
// - Sidetone source chosen by mode
// - CW sidetone divided to fixed tone
// - Normal transmit drives bias selects low
// - Battery check with key: bias high
// - Power reference follows power switch
// - Receive or off isolates power amplifier
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "hftx_map.svh"
module hftx_ctrl import hftx_pkg::*; #(
  parameter int DRV_N = 8,
  parameter int HARM_N = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Filter selection and amplifier relay
  output logic [DRV_N-1:0] drive_filter_en,
  output logic [HARM_N-1:0] harm_relay,
  output logic pa_connect,
  // Signal routing
  output logic speech_proc_en,
  output logic voice_gain_leveller_en,
  output logic message_unit_modem_source,
  output logic phasing_en,
  output logic carrier_imbalance_drive,
  output logic [1:0] sidetone_src,
  // Divided references and tones
  output logic carrier_0,
  output logic carrier_90,
  output logic modulator_a1,
  output logic modulator_a2,
  output logic modulator_b1,
  output logic modulator_b2,
  output logic sidetone_tone,
  // Power amplifier controls
  output logic [1:0] bias_sel,
  output logic [1:0] power_ref
);
  localparam int CW = 18;

  // Register file
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] filt_ff, nxt_filt;
  logic wr_pend_ff, nxt_wr_pend;
  logic [11:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;

  logic [2:0] mode;
  logic [2:0] pwr;
  logic tx, ptt;
  logic acc;
  assign mode = ctrl_ff[`HFTX_CTRL_MODE_LSB +: 3];
  assign pwr = ctrl_ff[`HFTX_CTRL_PWR_LSB +: 3];
  assign tx = ctrl_ff[`HFTX_CTRL_TX_BIT];
  assign ptt = ctrl_ff[`HFTX_CTRL_PTT_BIT];
  assign acc = hsel && hready && htrans[1];

  // Bus slave: zero-wait, writes land at the end of the data phase
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_filt = filt_ff;
    nxt_wr_pend = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_hrdata = hrdata_ff;
    if (wr_pend_ff) begin
      case (wr_addr_ff)
        `HFTX_OFF_CTRL: nxt_ctrl = {22'h0, hwdata[9:0]};
        `HFTX_OFF_FILT: nxt_filt = {26'h0, hwdata[5:4], 1'b0, hwdata[2:0]};
        default: ;
      endcase
    end
    if (acc) begin
      nxt_wr_pend = hwrite;
      nxt_wr_addr = {haddr[11:2], 2'h0};
      case ({haddr[11:2], 2'h0})
        `HFTX_OFF_CTRL: nxt_hrdata = ctrl_ff;
        `HFTX_OFF_FILT: nxt_hrdata = filt_ff;
        `HFTX_OFF_STAT: nxt_hrdata = {24'h0, bias_sel, power_ref, pa_connect,
                                      phasing_en, carrier_imbalance_drive, speech_proc_en};
        `HFTX_OFF_DRV: nxt_hrdata = {20'h0, harm_relay, drive_filter_en};
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `HFTX_CTRL_RESET;
      filt_ff <= `HFTX_FILT_RESET;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      filt_ff <= nxt_filt;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1; // Never stalls; every register is a flop
  assign hresp = 1'b0;

  // Decoded control outputs, all registered together
  logic [DRV_N-1:0] drv_ff, nxt_drv;
  logic [HARM_N-1:0] harm_ff, nxt_harm;
  logic [7:0] route_ff, nxt_route;
  logic [1:0] bias_ff, nxt_bias;
  logic [1:0] pref_ff, nxt_pref;
  logic [CW-1:0] tone_step;
  logic tone_run;

  // One-hot filter decodes in binary order
  genvar gi;
  generate
    for (gi = 0; gi < DRV_N; gi++) begin : g_drv
      assign nxt_drv[gi] = (filt_ff[2:0] == 3'(gi));
    end
    for (gi = 0; gi < HARM_N; gi++) begin : g_harm
      assign nxt_harm[gi] = tx && (filt_ff[5:4] == 2'(gi));
    end
  endgenerate

  // Mode routing: one vector so every switch moves in one edge
  // Bits: speech, leveller, modem src, phasing, imbalance, pa, sidetone[1:0]
  always_comb begin
    nxt_route = 8'h00;
    tone_run = 1'b0;
    tone_step = CW'(`HFTX_VOICE_QTR);
    case (mode)
      HFTX_MODE_VOICE: begin
        nxt_route = {1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, HFTX_SIDE_PREAMP};
        tone_run = 1'b1;
      end
      HFTX_MODE_MSG: begin
        nxt_route = {1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, HFTX_SIDE_BPF};
        tone_run = 1'b1;
        tone_step = CW'(`HFTX_MSG_QTR);
      end
      HFTX_MODE_DATA75, HFTX_MODE_DATA150, HFTX_MODE_DATA300: begin
        nxt_route = {1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, HFTX_SIDE_BPF};
        tone_run = 1'b1;
        tone_step = CW'(`HFTX_DATA_QTR);
      end
      HFTX_MODE_CW: begin
        nxt_route = {1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, HFTX_SIDE_CW};
      end
      default: nxt_route = {6'h00, HFTX_SIDE_NONE};
    endcase
    // Relay isolates the amplifier on receive or power off
    nxt_route[2] = tx && (pwr != HFTX_PWR_OFF);
  end

  // Bias and power reference from the power switch
  always_comb begin
    nxt_bias = 2'h0;
    if (tx && ptt && pwr == HFTX_PWR_BATT) begin
      nxt_bias = 2'h3;
    end
    case (pwr)
      HFTX_PWR_LOW: nxt_pref = 2'h1;
      HFTX_PWR_HIGH: nxt_pref = 2'h2;
      default: nxt_pref = 2'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drv_ff <= DRV_N'(1); // Code zero's line, so exactly one line is always on
      harm_ff <= '0;
      route_ff <= 8'h00;
      bias_ff <= 2'h0;
      pref_ff <= 2'h0;
    end else begin
      drv_ff <= nxt_drv;
      harm_ff <= nxt_harm;
      route_ff <= nxt_route;
      bias_ff <= nxt_bias;
      pref_ff <= nxt_pref;
    end
  end

  assign drive_filter_en = drv_ff;
  assign harm_relay = harm_ff;
  assign speech_proc_en = route_ff[7];
  assign voice_gain_leveller_en = route_ff[6];
  assign message_unit_modem_source = route_ff[5];
  assign phasing_en = route_ff[4];
  assign carrier_imbalance_drive = route_ff[3];
  assign pa_connect = route_ff[2];
  assign sidetone_src = route_ff[1:0];
  assign bias_sel = bias_ff;
  assign power_ref = pref_ff;

  // 1.2 MHz reference then divide-by-four to quadrature 300 kHz carriers
  logic [CW-1:0] qref_cnt_ff, nxt_qref_cnt;
  logic qref_tick;
  always_comb begin
    qref_tick = (qref_cnt_ff == CW'(`HFTX_QREF_HALF - 1));
    nxt_qref_cnt = qref_tick ? '0 : qref_cnt_ff + CW'(1);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qref_cnt_ff <= '0;
    end else begin
      qref_cnt_ff <= nxt_qref_cnt;
    end
  end

  // Two half-periods of the reference make one quarter of the carrier
  logic c0_w, c90_w, t0_w, t90_w;
  hftx_quad_div #(.CW(CW)) u_carrier (
    .clk(hclk),
    .rst_n(hresetn),
    .run(1'b1),
    .step(CW'(2 * `HFTX_QREF_HALF)),
    .q0(c0_w),
    .q90(c90_w)
  );

  // Modulating tone divider; held still in CW so phasing is off
  hftx_quad_div #(.CW(CW)) u_tone (
    .clk(hclk),
    .rst_n(hresetn),
    .run(tone_run),
    .step(tone_step),
    .q0(t0_w),
    .q90(t90_w)
  );

  // CW sidetone: fixed-level square wave
  logic [CW-1:0] side_cnt_ff, nxt_side_cnt;
  logic side_ff, nxt_side;
  always_comb begin
    nxt_side_cnt = side_cnt_ff;
    nxt_side = side_ff;
    if (mode != HFTX_MODE_CW) begin
      nxt_side_cnt = '0;
      nxt_side = 1'b0;
    end else if (side_cnt_ff == CW'(`HFTX_SIDE_HALF - 1)) begin
      nxt_side_cnt = '0;
      nxt_side = ~side_ff;
    end else begin
      nxt_side_cnt = side_cnt_ff + CW'(1);
    end
  end

  // Output staging for tones; modulator pairs gated by tone_run
  logic [6:0] tone_ff, nxt_tone;
  always_comb begin
    nxt_tone[0] = c0_w;
    nxt_tone[1] = c90_w;
    nxt_tone[2] = t0_w & tone_run;
    nxt_tone[3] = t90_w & tone_run;
    nxt_tone[4] = ~t0_w & tone_run;
    nxt_tone[5] = ~t90_w & tone_run;
    nxt_tone[6] = nxt_side;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      side_cnt_ff <= '0;
      side_ff <= 1'b0;
      tone_ff <= 7'h00;
    end else begin
      side_cnt_ff <= nxt_side_cnt;
      side_ff <= nxt_side;
      tone_ff <= nxt_tone;
    end
  end

  assign carrier_0 = tone_ff[0];
  assign carrier_90 = tone_ff[1];
  assign modulator_a1 = tone_ff[2];
  assign modulator_a2 = tone_ff[3];
  assign modulator_b1 = tone_ff[4];
  assign modulator_b2 = tone_ff[5];
  assign sidetone_tone = tone_ff[6];

  // Checks
  drv_onehot_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot(drive_filter_en)) else $error("drive filter select not one-hot");
  drv_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    drive_filter_en == DRV_N'(1) << $past(filt_ff[2:0])) else $error("wrong drive filter");
  harm_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(tx) |-> harm_relay == HARM_N'(1) << $past(filt_ff[5:4]))
    else $error("wrong harmonic relay");
  harm_rx_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(tx) |-> harm_relay == '0) else $error("relay energised on receive");
  speech_voice_a: assert property (@(posedge hclk) disable iff (!hresetn)
    speech_proc_en == ($past(mode) == HFTX_MODE_VOICE)) else $error("speech path wrong");
  antiphase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    speech_proc_en |-> modulator_b1 == !modulator_a1) else $error("second pair not antiphase");
  cw_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    carrier_imbalance_drive |-> !phasing_en && !modulator_a1) else $error("cw phasing on");
  bias_batt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(tx) && $past(ptt) && $past(pwr) == HFTX_PWR_BATT) == (bias_sel == 2'h3))
    else $error("bias select wrong");
  pa_iso_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!$past(tx) || $past(pwr) == HFTX_PWR_OFF) |-> !pa_connect) else $error("pa not isolated");
  same_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(phasing_en) |-> $changed(sidetone_src) || $changed(speech_proc_en)
      || $changed(carrier_imbalance_drive) || $changed(message_unit_modem_source))
    else $error("routing split over edges");
  // Carrier phases only step on every second reference half-period
  carrier_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($changed(c0_w) || $changed(c90_w)) |-> $past(qref_tick))
    else $error("carrier off reference");
endmodule : hftx_ctrl

// *** rtl/hftx_map.svh ***
// Constants for the transmit path control block: offsets, fields, resets, timing.
// Assumes inclusion by the design modules and the testbench only.
`ifndef HFTX_MAP_SVH
`define HFTX_MAP_SVH

// Register byte offsets
`define HFTX_OFF_CTRL 12'h000
`define HFTX_OFF_FILT 12'h004
`define HFTX_OFF_STAT 12'h008
`define HFTX_OFF_DRV 12'h00c

// Control register fields
`define HFTX_CTRL_MODE_LSB 0
`define HFTX_CTRL_PWR_LSB 4
`define HFTX_CTRL_TX_BIT 8
`define HFTX_CTRL_PTT_BIT 9
`define HFTX_CTRL_RESET 32'h0000_0000

// Filter register fields
`define HFTX_FILT_DRV_LSB 0
`define HFTX_FILT_HARM_LSB 4
`define HFTX_FILT_RESET 32'h0000_0000

// Clock and reference rates in Hz
`define HFTX_CLK_HZ 250000000
`define HFTX_REF_HZ 4800000
`define HFTX_QREF_HZ 1200000
`define HFTX_SIDETONE_HZ 1200
`define HFTX_VOICE_TONE_HZ 1700
`define HFTX_MSG_TONE_HZ 2200
`define HFTX_DATA_TONE_HZ 2000

// Half-periods in system clocks of the divided references
`define HFTX_QREF_HALF ((`HFTX_CLK_HZ / `HFTX_QREF_HZ) / 2)
`define HFTX_SIDE_HALF ((`HFTX_CLK_HZ / `HFTX_SIDETONE_HZ) / 2)
// Quarter periods of the quadrature tones
`define HFTX_VOICE_QTR ((`HFTX_CLK_HZ / `HFTX_VOICE_TONE_HZ) / 4)
`define HFTX_MSG_QTR ((`HFTX_CLK_HZ / `HFTX_MSG_TONE_HZ) / 4)
`define HFTX_DATA_QTR ((`HFTX_CLK_HZ / `HFTX_DATA_TONE_HZ) / 4)

`endif

// *** rtl/hftx_pkg.sv ***
// Types for the transmit path control block.
// Assumes the map header sits beside it in rtl/.
package hftx_pkg;
  // Mode switch encodings
  typedef enum logic [2:0] {
    HFTX_MODE_CW, HFTX_MODE_VOICE, HFTX_MODE_DATA75, HFTX_MODE_DATA150,
    HFTX_MODE_DATA300, HFTX_MODE_MSG
  } hftx_mode_e;
  // Power switch encodings
  typedef enum logic [2:0] {
    HFTX_PWR_OFF, HFTX_PWR_TEST, HFTX_PWR_LOW, HFTX_PWR_HIGH, HFTX_PWR_BATT,
    HFTX_PWR_STANDBY
  } hftx_pwr_e;
  // Tone-source selection
  typedef enum logic [1:0] {
    HFTX_SIDE_PREAMP, HFTX_SIDE_BPF, HFTX_SIDE_CW, HFTX_SIDE_NONE
  } hftx_side_e;
  // Bus transfer states
  typedef enum logic [1:0] {HFTX_HTRANS_IDLE = 2'h0, HFTX_HTRANS_NONSEQ = 2'h2} hftx_htrans_e;
endpackage : hftx_pkg

// *** rtl/hftx_quad_div.sv ***
// Quadrature divider: a divide-by-four of a quarter-period count of step clocks.
// Assumes one system clock; period words change only between enables.
`timescale 1ns/1ps
`include "hftx_map.svh"
module hftx_quad_div import hftx_pkg::*; #(
  parameter int CW = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [CW-1:0] step,
  // Quadrature outputs
  output logic q0,
  output logic q90
);
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [1:0] ph_ff, nxt_ph;

  // Count step cycles per quarter, then advance a two-bit Johnson phase
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_ph = ph_ff;
    if (!run) begin
      nxt_cnt = '0;
      nxt_ph = 2'h0;
    end else if (cnt_ff >= step - CW'(1)) begin
      nxt_cnt = '0;
      nxt_ph = {ph_ff[0], ~ph_ff[1]};
    end else begin
      nxt_cnt = cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      ph_ff <= 2'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      ph_ff <= nxt_ph;
    end
  end

  // Johnson bits are a quarter period apart
  assign q0 = ph_ff[0];
  assign q90 = ph_ff[1];
endmodule : hftx_quad_div
